/* File: inc/mmsc_defs.svh */
// Constants of the module management status and control block.
// Assumes a 10 MHz management clock; included by bare name.
`ifndef MMSC_DEFS_SVH
`define MMSC_DEFS_SVH

// Clock rate and derived cycle scales
`define MMSC_CLK_HZ 10000000
`define MMSC_CYC_PER_MS (`MMSC_CLK_HZ / 1000)
`define MMSC_CYC_PER_US (`MMSC_CLK_HZ / 1000000)
// Cycles reserved for pin synchronisers and output flops
`define MMSC_MARGIN_CYC 4

// Latency limits, each in its own unit
`define MMSC_T_DATA_MS 2000
`define MMSC_T_MASK_MS 100
`define MMSC_T_PDOWN_ON_MS 100
`define MMSC_T_PDOWN_OFF_MS 300
`define MMSC_T_LPPIN_ON_US 100
`define MMSC_T_RXSQ_ON_US 80
`define MMSC_T_RXSQ_OFF_MS 1
`define MMSC_T_TXSQ_MS 400
`define MMSC_T_TXDIS_ON_MS 100
`define MMSC_T_TXDIS_OFF_MS 400
`define MMSC_T_RXDIS_MS 100
`define MMSC_T_SQDIS_MS 100

// Link clock watchdog: cycles without a link clock edge
`define MMSC_LINK_TIMEOUT 8'h10

// Serial bus address (7-bit form of A0h)
`define MMSC_DEV_ADDR 7'h50

// Memory map
`define MMSC_A_STATUS 8'h02
`define MMSC_A_LOS 8'h03
`define MMSC_A_FAULT 8'h04
`define MMSC_A_TXDIS 8'h56
`define MMSC_A_PWR 8'h5d
`define MMSC_A_MASK_LOS 8'h64
`define MMSC_A_MASK_FLT 8'h65
`define MMSC_A_PAGE 8'h7f
`define MMSC_A_SQDIS 8'hf0
`define MMSC_A_RXDIS 8'hf1
`define MMSC_PAGE_CTRL 8'h03
`define MMSC_UPPER_BIT 7

// Field positions
`define MMSC_B_DNR 0
`define MMSC_B_ALERT 1
`define MMSC_B_LPREQ 1

`endif

/* File: inc/mmsc_pkg.sv */
// Types of the module management status and control block.
// Assumes four electrical lanes muxed onto two optical lanes.
package mmsc_pkg;

  // Latched event flags
  typedef struct packed {
    logic [3:0] tx_fault;
    logic [3:0] tx_los;
    logic [3:0] rx_los;
  } mmsc_flags_t;

  // Software controls held in the memory
  typedef struct packed {
    logic [3:0] rx_dis;
    logic [3:0] rx_sqdis;
    logic [3:0] tx_sqdis;
    logic [3:0] tx_dis;
    logic lp_req;
  } mmsc_ctrl_t;

  // Host side memory transaction
  typedef struct packed {
    logic [6:0] dev;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } mmsc_req_t;

  // Start-up sequence
  typedef enum logic [1:0] {
    MMSC_ST_INIT = 2'b01,
    MMSC_ST_RUN = 2'b10
  } mmsc_state_t;

endpackage

/* File: design/mmsc_settle.sv */
// Level follower with separate rise and fall latency.
// Assumes input and output in the one management clock domain.
module mmsc_settle
  import mmsc_pkg::*;
#(
  parameter logic [24:0] ON_CYC = 25'h1,
  parameter logic [24:0] OFF_CYC = 25'h1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Level in and settled level out
  input wire logic d_i,
  output logic q_o
);

  logic [24:0] cnt_q;
  logic q_q;

  // Target count for the pending change
  wire logic [24:0] limit = d_i ? ON_CYC : OFF_CYC;
  wire logic differ = d_i != q_q;
  wire logic done = differ && (cnt_q >= limit - 25'h1);

  // Count while the input differs, restart when it agrees
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 25'h0;
      q_q <= 1'b0;
    end else begin
      cnt_q <= (differ && !done) ? cnt_q + 25'h1 : 25'h0;
      if (done) begin
        q_q <= d_i;
      end
    end
  end

  assign q_o = q_q;

endmodule

/* File: design/mmsc_top.sv */
// Management status and control of a pluggable optical module.
// Assumes host transactions decoded from the two-wire bus, one per cycle,
// and link-side conditions arriving asynchronously on pins.
`include "mmsc_defs.svh"

module mmsc_top
  import mmsc_pkg::*;
#(
  parameter logic [24:0] INIT_CYC =
    25'(`MMSC_T_DATA_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC),
  parameter logic [24:0] MASK_CYC =
    25'(`MMSC_T_MASK_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC),
  parameter logic [24:0] LP_ON_CYC =
    25'(`MMSC_T_PDOWN_ON_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC),
  parameter logic [24:0] LP_OFF_CYC =
    25'(`MMSC_T_PDOWN_OFF_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC),
  parameter logic [24:0] RXSQ_OFF_CYC =
    25'(`MMSC_T_RXSQ_OFF_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC),
  parameter logic [24:0] TXSQ_CYC =
    25'(`MMSC_T_TXSQ_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC),
  parameter logic [24:0] TXDIS_ON_CYC =
    25'(`MMSC_T_TXDIS_ON_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC),
  parameter logic [24:0] TXDIS_OFF_CYC =
    25'(`MMSC_T_TXDIS_OFF_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC),
  parameter logic [24:0] RXDIS_CYC =
    25'(`MMSC_T_RXDIS_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC),
  parameter logic [24:0] SQDIS_CYC =
    25'(`MMSC_T_SQDIS_MS * `MMSC_CYC_PER_MS - `MMSC_MARGIN_CYC)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Host memory transaction, one-cycle strobes
  input wire mmsc_req_t req_i,
  output logic [7:0] rdata_q,
  output logic ack_q,
  // Asynchronous link-side conditions and pins
  input wire logic link_clk,
  input wire logic [3:0] rx_los_i,
  input wire logic [3:0] tx_los_i,
  input wire logic [3:0] tx_fault_i,
  input wire logic lp_mode_i,
  // Open-drain alert, active low
  output logic module_alert_n_o,
  output logic module_alert_n_oe_n,
  // Datapath controls
  output logic low_power_q,
  output logic [1:0] tx_out_en_q,
  output logic [3:0] rx_out_en_q,
  output logic data_ready_q
);

  // Receive squelch assert count sits below the 4096 parameter threshold
  localparam logic [24:0] RXSQ_ON_CYC =
    25'(`MMSC_T_RXSQ_ON_US * `MMSC_CYC_PER_US - `MMSC_MARGIN_CYC);
  localparam logic [24:0] LPPIN_CYC =
    25'(`MMSC_T_LPPIN_ON_US * `MMSC_CYC_PER_US - `MMSC_MARGIN_CYC);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [13:0] sync1_q;
  logic [13:0] sync2_q;

  // Two flops for every asynchronous input
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 14'h0;
      sync2_q <= 14'h0;
    end else begin
      sync1_q <= {link_clk, lp_mode_i, tx_fault_i, tx_los_i, rx_los_i};
      sync2_q <= sync1_q;
    end
  end

  wire logic [3:0] rx_los_s = sync2_q[3:0];
  wire logic [3:0] tx_los_s = sync2_q[7:4];
  wire logic [3:0] tx_fault_s = sync2_q[11:8];
  wire logic lp_pin_s = sync2_q[12];
  wire logic link_clk_s = sync2_q[13];

  // ---------------------------------------------------------------
  // Link clock activity watchdog
  // ---------------------------------------------------------------
  logic link_clk_d_q;
  logic [7:0] link_idle_q;

  // Count cycles since the last link clock edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_clk_d_q <= 1'b0;
      link_idle_q <= 8'h0;
    end else begin
      link_clk_d_q <= link_clk_s;
      if (link_clk_d_q != link_clk_s) begin
        link_idle_q <= 8'h0;
      end else if (link_idle_q != `MMSC_LINK_TIMEOUT) begin
        link_idle_q <= link_idle_q + 8'h1;
      end
    end
  end

  wire logic link_dead = link_idle_q == `MMSC_LINK_TIMEOUT;
  // Transmit input lost per lane: pin flag or no link clock
  wire logic [3:0] tx_in_lost = tx_los_s | {4{link_dead}};

  // ---------------------------------------------------------------
  // Start-up sequence
  // ---------------------------------------------------------------
  mmsc_state_t state_q;
  logic [24:0] init_cnt_q;
  wire logic init_done = init_cnt_q >= INIT_CYC - 25'h1;

  // Hold not-ready until the start-up count expires
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= MMSC_ST_INIT;
      init_cnt_q <= 25'h0;
    end else begin
      unique case (state_q)
        MMSC_ST_INIT: begin
          init_cnt_q <= init_cnt_q + 25'h1;
          if (init_done) begin
            state_q <= MMSC_ST_RUN;
          end
        end
        MMSC_ST_RUN: begin
          init_cnt_q <= 25'h0;
        end
      endcase
    end
  end

  wire logic running = state_q == MMSC_ST_RUN;

  // ---------------------------------------------------------------
  // Memory decode
  // ---------------------------------------------------------------
  logic [7:0] page_q;
  mmsc_ctrl_t ctrl_q;
  logic [11:0] mask_q;
  mmsc_flags_t flags_q;
  logic ready_flag_q;
  logic alert_q;

  // Hit on a location, upper half only on the given page
  function automatic logic at(input logic [7:0] a, input logic [7:0] pg,
                              input logic [7:0] loc, input logic [7:0] want);
    at = (a == loc) && (!loc[`MMSC_UPPER_BIT] || pg == want);
  endfunction

  wire logic sel = req_i.dev == `MMSC_DEV_ADDR;
  wire logic do_rd = sel && req_i.rd;
  wire logic do_wr = sel && req_i.wr;
  wire logic [7:0] a = req_i.addr;
  wire logic [7:0] pctl = `MMSC_PAGE_CTRL;

  wire logic hit_status = at(a, page_q, `MMSC_A_STATUS, pctl);
  wire logic hit_los = at(a, page_q, `MMSC_A_LOS, pctl);
  wire logic hit_fault = at(a, page_q, `MMSC_A_FAULT, pctl);
  wire logic hit_txdis = at(a, page_q, `MMSC_A_TXDIS, pctl);
  wire logic hit_pwr = at(a, page_q, `MMSC_A_PWR, pctl);
  wire logic hit_mlos = at(a, page_q, `MMSC_A_MASK_LOS, pctl);
  wire logic hit_mflt = at(a, page_q, `MMSC_A_MASK_FLT, pctl);
  wire logic hit_page = at(a, page_q, `MMSC_A_PAGE, pctl);
  wire logic hit_sqdis = at(a, page_q, `MMSC_A_SQDIS, pctl);
  wire logic hit_rxdis = at(a, page_q, `MMSC_A_RXDIS, pctl);

  // Status byte: not-ready in bit 0, alert soft copy in bit 1
  wire logic [7:0] status_byte = 8'({alert_q, !running} << `MMSC_B_DNR);

  // Read data selection; every other location, monitors too, reads zero
  wire logic [7:0] rd_mux =
    hit_status ? status_byte :
    hit_los ? {flags_q.tx_los, flags_q.rx_los} :
    hit_fault ? {4'h0, flags_q.tx_fault} :
    hit_txdis ? {4'h0, ctrl_q.tx_dis} :
    hit_pwr ? 8'({ctrl_q.lp_req} << `MMSC_B_LPREQ) :
    hit_mlos ? mask_q[7:0] :
    hit_mflt ? {4'h0, mask_q[11:8]} :
    hit_page ? page_q :
    hit_sqdis ? {ctrl_q.rx_sqdis, ctrl_q.tx_sqdis} :
    hit_rxdis ? {ctrl_q.rx_dis, 4'h0} :
    8'h00;

  // Read answer registered one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end else begin
      ack_q <= do_rd || do_wr;
      if (do_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Writable controls; all volatile, zero after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= 8'h00;
      ctrl_q <= '0;
      mask_q <= 12'h0;
    end else if (do_wr) begin
      if (hit_page) page_q <= req_i.wdata;
      if (hit_txdis) ctrl_q.tx_dis <= req_i.wdata[3:0];
      if (hit_pwr) ctrl_q.lp_req <= req_i.wdata[`MMSC_B_LPREQ];
      if (hit_mlos) mask_q[7:0] <= req_i.wdata;
      if (hit_mflt) mask_q[11:8] <= req_i.wdata[3:0];
      if (hit_sqdis) {ctrl_q.rx_sqdis, ctrl_q.tx_sqdis} <= req_i.wdata;
      if (hit_rxdis) ctrl_q.rx_dis <= req_i.wdata[7:4];
    end
  end

  // ---------------------------------------------------------------
  // Latched flags and alert
  // ---------------------------------------------------------------
  wire mmsc_flags_t cond = '{tx_fault: tx_fault_s, tx_los: tx_in_lost,
                             rx_los: rx_los_s};
  wire logic [11:0] clr_flags = {{4{do_rd && hit_fault}}, {8{do_rd && hit_los}}};
  wire logic clr_ready = do_rd && hit_status;
  logic [11:0] mask_eff;

  // Conditions set flags; a read clears, a set in the same cycle wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
      ready_flag_q <= 1'b0;
    end else begin
      flags_q <= (flags_q & ~clr_flags) | cond;
      ready_flag_q <= (ready_flag_q && !clr_ready) ||
                      (state_q == MMSC_ST_INIT && init_done);
    end
  end

  // Alert from unmasked flags or the ready event; released on clear
  wire logic alert_d = ready_flag_q || |(flags_q & ~mask_eff);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alert_q <= 1'b0;
      module_alert_n_o <= 1'b0;
      module_alert_n_oe_n <= 1'b1;
    end else begin
      alert_q <= alert_d;
      module_alert_n_o <= 1'b0;
      module_alert_n_oe_n <= !alert_d;
    end
  end

  // ---------------------------------------------------------------
  // Settled controls, each on its own latency counter
  // ---------------------------------------------------------------
  logic lp_soft_eff;
  logic lp_pin_eff;
  logic [1:0] txdis_eff;
  logic [3:0] rxdis_eff;
  logic [3:0] txsqd_eff;
  logic [3:0] rxsqd_eff;
  logic [3:0] rxsq;
  logic [1:0] txsq;

  mmsc_settle #(.ON_CYC(LP_ON_CYC), .OFF_CYC(LP_OFF_CYC)) u_lp_soft (
    .clock(clock), .rst_n(rst_n), .d_i(ctrl_q.lp_req), .q_o(lp_soft_eff));
  mmsc_settle #(.ON_CYC(LPPIN_CYC), .OFF_CYC(LP_OFF_CYC)) u_lp_pin (
    .clock(clock), .rst_n(rst_n), .d_i(lp_pin_s), .q_o(lp_pin_eff));

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_mask
      mmsc_settle #(.ON_CYC(MASK_CYC), .OFF_CYC(MASK_CYC)) u_m (
        .clock(clock), .rst_n(rst_n), .d_i(mask_q[gi]), .q_o(mask_eff[gi]));
    end
    for (gi = 0; gi < 4; gi++) begin : g_lane
      mmsc_settle #(.ON_CYC(RXDIS_CYC), .OFF_CYC(RXDIS_CYC)) u_rxdis (
        .clock(clock), .rst_n(rst_n), .d_i(ctrl_q.rx_dis[gi]),
        .q_o(rxdis_eff[gi]));
      mmsc_settle #(.ON_CYC(SQDIS_CYC), .OFF_CYC(SQDIS_CYC)) u_txsqd (
        .clock(clock), .rst_n(rst_n), .d_i(ctrl_q.tx_sqdis[gi]),
        .q_o(txsqd_eff[gi]));
      mmsc_settle #(.ON_CYC(SQDIS_CYC), .OFF_CYC(SQDIS_CYC)) u_rxsqd (
        .clock(clock), .rst_n(rst_n), .d_i(ctrl_q.rx_sqdis[gi]),
        .q_o(rxsqd_eff[gi]));
      mmsc_settle #(.ON_CYC(RXSQ_ON_CYC), .OFF_CYC(RXSQ_OFF_CYC)) u_rxsq (
        .clock(clock), .rst_n(rst_n), .d_i(rx_los_s[gi]), .q_o(rxsq[gi]));
    end
    // Two electrical lanes share one optical lane
    for (gi = 0; gi < 2; gi++) begin : g_opt
      mmsc_settle #(.ON_CYC(TXDIS_ON_CYC), .OFF_CYC(TXDIS_OFF_CYC)) u_txdis (
        .clock(clock), .rst_n(rst_n), .d_i(|ctrl_q.tx_dis[2*gi +: 2]),
        .q_o(txdis_eff[gi]));
      mmsc_settle #(.ON_CYC(TXSQ_CYC), .OFF_CYC(TXSQ_CYC)) u_txsq (
        .clock(clock), .rst_n(rst_n), .d_i(|tx_in_lost[2*gi +: 2]),
        .q_o(txsq[gi]));
    end
  endgenerate

  // ---------------------------------------------------------------
  // Datapath control outputs
  // ---------------------------------------------------------------
  wire logic lp_eff = lp_soft_eff || lp_pin_eff;
  // Squelch applies unless any lane of the pair disables it
  wire logic [1:0] tx_sq_on = txsq & ~{|txsqd_eff[3:2], |txsqd_eff[1:0]};
  wire logic [3:0] rx_sq_on = rxsq & ~rxsqd_eff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_power_q <= 1'b0;
      tx_out_en_q <= 2'h0;
      rx_out_en_q <= 4'h0;
      data_ready_q <= 1'b0;
    end else begin
      low_power_q <= lp_eff;
      tx_out_en_q <= ~(txdis_eff | tx_sq_on | {2{lp_eff}});
      rx_out_en_q <= ~(rxdis_eff | rx_sq_on | {4{lp_eff}});
      data_ready_q <= running;
    end
  end

endmodule

/* File: bench/mmsc_assertions.sv */
// Port-level checks for the module management status and control block.
// Assumes it is bound into mmsc_top with the start-up count handed on.
module mmsc_assertions
  import mmsc_pkg::*;
#(
  parameter logic [24:0] INIT_CYC = 25'h32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Memory port
  input wire mmsc_req_t req_i,
  input wire logic [7:0] rdata_q,
  input wire logic ack_q,
  // Conditions
  input wire logic [3:0] rx_los_i,
  input wire logic [3:0] tx_fault_i,
  // Alert and datapath
  input wire logic module_alert_n_oe_n,
  input wire logic low_power_q,
  input wire logic [1:0] tx_out_en_q,
  input wire logic [3:0] rx_out_en_q,
  input wire logic data_ready_q
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------
  // Helpers
  // --------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Accepted requests and flag byte reads
  wire logic hit = (req_i.rd | req_i.wr) & (req_i.dev == 7'h50);
  wire logic rd3 = hit & req_i.rd & (req_i.addr == 8'h03);
  wire logic rd4 = hit & req_i.rd & (req_i.addr == 8'h04);
  logic [24:0] up_q;

  // Cycles since reset, saturating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 25'h0;
    end else if (up_q != 25'h1ffffff) begin
      up_q <= up_q + 25'h1;
    end
  end

  // --------------------------------
  // Assertions
  // --------------------------------
  ack_on_a: assert property (hit |=> ack_q)
    else $error("accepted request got no ack");
  ack_off_a: assert property (!hit |=> !ack_q)
    else $error("ack without accepted request");
  rx_flag_a: assert property (rx_los_i[0] [*5] ##0 rd3 |=> rdata_q[0])
    else $error("receive loss flag not set");
  flt_flag_a: assert property (tx_fault_i[0] [*5] ##0 rd4 |=> rdata_q[0])
    else $error("transmit fault flag not set");
  flag_clear_a: assert property ((!rx_los_i[0]) [*6] ##0 rd3 ##1 rd3 |=> !rdata_q[0])
    else $error("flag survived its read");
  monitor_zero_a: assert property (
    hit && req_i.rd && req_i.addr inside {[8'h16:8'h21]} |=> rdata_q == 8'h00)
    else $error("monitor byte not zero");
  ready_time_a: assert property (up_q >= INIT_CYC + 25'h3 |-> data_ready_q)
    else $error("start-up not done in time");
  ready_alert_a: assert property ($rose(data_ready_q) |-> ##[0:2] !module_alert_n_oe_n)
    else $error("ready without alert");
  low_power_a: assert property (low_power_q [*3] |-> tx_out_en_q == 2'h0 && rx_out_en_q == 4'h0)
    else $error("outputs on in low power");

  // Main scenarios reached
  cover property ($rose(data_ready_q));
  cover property ($fell(module_alert_n_oe_n));
  cover property ($rose(low_power_q));
endmodule

/* File: bench/mmsc_host_model.sv */
// Host controller side of the memory port: one byte transfer at a time.
// Assumes the block takes a strobe at the rising edge and acks a cycle on.
module mmsc_host_model
  import mmsc_pkg::*;
(
  // Clock
  input wire logic clock,
  // Request towards the block
  output mmsc_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_o = '0;

  // Raise one transfer after a falling edge, held over the taking edge
  task automatic access(input logic [6:0] dev, input logic [7:0] a,
                        input logic [7:0] d, input logic w);
    @(negedge clock);
    req_o = '{dev: dev, addr: a, wdata: d, rd: !w, wr: w};
    @(posedge clock);
  endtask

  // Drop the strobes after the last transfer
  task automatic idle();
    @(negedge clock);
    req_o = '0;
  endtask
endmodule

/* File: bench/mmsc_top_tb.sv */
// Self-checking bench for the module management status and control block.
// Assumes short latency parameters; host model drives the memory port.
module mmsc_top_tb
  import mmsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Shortened latency counts and observed bit positions
  localparam int INIT = 32'h32;
  localparam int MSK = 32'h1e;
  localparam int LPON = 32'h14;
  localparam int LPOFF = 32'h28;
  localparam int SQ = 32'h1e;
  localparam int DIS = 32'h14;
  localparam int TXOFF = 32'h28;
  localparam int TX0 = 4;
  localparam int OE = 6;
  localparam int LP = 7;
  localparam int RDY = 8;
  // Design hookup
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic link_clk = 1'b0;
  logic link_run = 1'b1;
  logic [3:0] rx_los_i = 4'h0;
  logic [3:0] tx_los_i = 4'h0;
  logic [3:0] tx_fault_i = 4'h0;
  logic lp_mode_i = 1'b0;
  mmsc_req_t req_i;
  logic [7:0] rdata_q;
  logic ack_q, module_alert_n_oe_n, low_power_q, data_ready_q;
  logic module_alert_n_o;
  // Alert pin as the host sees it, pulled up when released
  wire logic alert_pin = module_alert_n_oe_n ? 1'b1 : module_alert_n_o;
  logic [1:0] tx_out_en_q;
  logic [3:0] rx_out_en_q;
  wire logic [8:0] obs = {data_ready_q, low_power_q, module_alert_n_oe_n, tx_out_en_q, rx_out_en_q};
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int bad_count = 0;
  int compares = 0;
  int ln;

  // Clocks: management and link clock, the latter stopped while link_run is low
  initial forever #50 clock = ~clock;
  always #400 if (link_run) link_clk = ~link_clk;

  mmsc_host_model i_mmsc_host_model (.clock(clock), .req_o(req_i));
  mmsc_top #(.INIT_CYC(25'(INIT)), .MASK_CYC(25'(MSK)), .LP_ON_CYC(25'(LPON)),
    .LP_OFF_CYC(25'(LPOFF)), .RXSQ_OFF_CYC(25'(SQ)), .TXSQ_CYC(25'(SQ)),
    .TXDIS_ON_CYC(25'(DIS)), .TXDIS_OFF_CYC(25'(TXOFF)), .RXDIS_CYC(25'(DIS)),
    .SQDIS_CYC(25'(DIS))) i_mmsc_top (.clock(clock), .rst_n(rst_n), .req_i(req_i),
    .rdata_q(rdata_q), .ack_q(ack_q), .link_clk(link_clk), .rx_los_i(rx_los_i),
    .tx_los_i(tx_los_i), .tx_fault_i(tx_fault_i), .lp_mode_i(lp_mode_i),
    .module_alert_n_o(module_alert_n_o), .module_alert_n_oe_n(module_alert_n_oe_n),
    .low_power_q(low_power_q), .tx_out_en_q(tx_out_en_q), .rx_out_en_q(rx_out_en_q),
    .data_ready_q(data_ready_q));

  // Comparison, verdict and bounded waits
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] x);
    compares++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_on(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (obs[i] !== v && n <= lim) begin
      @(negedge clock);
      n++;
    end
    check($sformatf("obs%0d", i), 8'(obs[i]), 8'(v));
    if (n > lim) end_of_test();
  endtask
  task automatic hold(input int i, input logic v, input int c);
    repeat (c) begin
      @(negedge clock);
      check($sformatf("hold%0d", i), 8'(obs[i]), 8'(v));
    end
  endtask
  // Transfers note their expected read byte and mask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [15:0] x);
    exp_q.push_back(x);
    i_mmsc_host_model.access(7'h50, a, d, w);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
    xfer(1'b0, a, 8'h00, {m, x});
    i_mmsc_host_model.idle();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 16'h0000);
    i_mmsc_host_model.idle();
  endtask

  // Watcher: each ack takes the oldest note
  always @(negedge clock) if (ack_q === 1'b1) begin
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hffff;
    if (e[15:8] != 8'h00) check("rdata", rdata_q & e[15:8], e[7:0]);
  end

  initial begin
    void'($urandom(32'h22ae0bc6));
    repeat (12) @(negedge clock);
    check("oe_n_reset", 8'(module_alert_n_oe_n), 8'h01);
    rst_n = 1'b1;
    wait_on(RDY, 1'b1, INIT + 8);
    wait_on(OE, 1'b0, 4);
    rd(8'h02, 8'h00, 8'h01);
    wait_on(OE, 1'b1, 10);
    i_mmsc_host_model.access(7'h51, 8'h02, 8'h00, 1'b0);
    i_mmsc_host_model.idle();
    rd(8'h16, 8'h00, 8'hff);
    // Receive loss, then back-to-back reads clear it
    rx_los_i[0] = 1'b1;
    wait_on(OE, 1'b0, 8);
    check("alert_pin", 8'(alert_pin), 8'h00);
    // Read while the loss still stands: the set wins over the clear
    rd(8'h03, 8'h01, 8'h0f);
    rx_los_i = 4'h0;
    repeat (6) @(negedge clock);
    xfer(1'b0, 8'h03, 8'h00, 16'h0f01);
    xfer(1'b0, 8'h03, 8'h00, 16'h0f00);
    i_mmsc_host_model.idle();
    wait_on(OE, 1'b1, 10);
    check("alert_pin", 8'(alert_pin), 8'h01);
    // Fault on lane 0 and a random lane, then transmit loss
    ln = $urandom_range(3, 0);
    tx_fault_i = 4'h1 | (4'h1 << ln);
    wait_on(OE, 1'b0, 8);
    rd(8'h04, 8'h01 | (8'h01 << ln), 8'h0f);
    tx_fault_i = 4'h0;
    repeat (6) @(negedge clock);
    rd(8'h04, 8'h01 | (8'h01 << ln), 8'h0f);
    wait_on(OE, 1'b1, 10);
    tx_los_i[1] = 1'b1;
    wait_on(OE, 1'b0, 8);
    tx_los_i = 4'h0;
    repeat (6) @(negedge clock);
    rd(8'h03, 8'h20, 8'hf0);
    // Mask holds the alert back, unmask lets it through
    wr(8'h64, 8'hff);
    repeat (MSK + 8) @(negedge clock);
    rx_los_i[2] = 1'b1;
    hold(OE, 1'b1, 12);
    wr(8'h64, 8'h00);
    wait_on(OE, 1'b0, MSK + 8);
    rx_los_i = 4'h0;
    repeat (6) @(negedge clock);
    rd(8'h03, 8'h04, 8'h0f);
    // Low power by soft bit and by pin
    wr(8'h5d, 8'h02);
    wait_on(LP, 1'b1, LPON + 8);
    wr(8'h5d, 8'h00);
    wait_on(LP, 1'b0, LPOFF + 8);
    wait_on(TX0, 1'b1, 8);
    lp_mode_i = 1'b1;
    wait_on(LP, 1'b1, 1010);
    lp_mode_i = 1'b0;
    wait_on(LP, 1'b0, LPOFF + 8);
    // Transmit disable on the first optical lane
    wr(8'h56, 8'h02);
    rd(8'h56, 8'h02, 8'h0f);
    wait_on(TX0, 1'b0, DIS + 8);
    check("tx_lane1", 8'(tx_out_en_q[1]), 8'h01);
    wr(8'h56, 8'h00);
    wait_on(TX0, 1'b1, TXOFF + 8);
    // Upper page 3: receive disable
    wr(8'h7f, 8'h03);
    wr(8'hf1, 8'h20);
    rd(8'hf1, 8'h20, 8'hf0);
    wait_on(1, 1'b0, DIS + 8);
    wr(8'hf1, 8'h00);
    wait_on(1, 1'b1, DIS + 8);
    // Receive squelch, then with squelch disabled
    rx_los_i[3] = 1'b1;
    wait_on(3, 1'b0, 810);
    rx_los_i = 4'h0;
    wait_on(3, 1'b1, SQ + 8);
    rd(8'h03, 8'h08, 8'h0f);
    wr(8'hf0, 8'h80);
    repeat (DIS + 8) @(negedge clock);
    rx_los_i[3] = 1'b1;
    hold(3, 1'b1, 820);
    rx_los_i = 4'h0;
    wr(8'hf0, 8'h00);
    rd(8'h03, 8'h08, 8'h0f);
    wr(8'h7f, 8'h00);
    rd(8'hf1, 8'h00, 8'hff);
    // Link clock stops: transmit squelch both ways
    link_run = 1'b0;
    wait_on(TX0, 1'b0, SQ + 30);
    link_run = 1'b1;
    wait_on(TX0, 1'b1, SQ + 30);
    // Transmit squelch disabled on the first optical lane only
    wr(8'h7f, 8'h03);
    wr(8'hf0, 8'h01);
    repeat (DIS + 8) @(negedge clock);
    link_run = 1'b0;
    hold(TX0, 1'b1, 60);
    check("tx_lane1_sq", 8'(tx_out_en_q[1]), 8'h00);
    link_run = 1'b1;
    wr(8'hf0, 8'h00);
    repeat (4) @(negedge clock);
    end_of_test();
  end
endmodule

bind mmsc_top mmsc_assertions #(.INIT_CYC(INIT_CYC)) i_mmsc_assertions (
  .clock(clock), .rst_n(rst_n), .req_i(req_i), .rdata_q(rdata_q), .ack_q(ack_q),
  .rx_los_i(rx_los_i), .tx_fault_i(tx_fault_i), .module_alert_n_oe_n(module_alert_n_oe_n),
  .low_power_q(low_power_q), .tx_out_en_q(tx_out_en_q), .rx_out_en_q(rx_out_en_q),
  .data_ready_q(data_ready_q));
